// ==== logic/keypad_parameter_editor.sv ====
/*
 keypad_parameter_editor: front-panel key interpreter for a drive.
 Holds function selection, edit value with clamping, protection flags,
 commit and all-save sequencing, and display state; registers over APB.
 Assumes key inputs are raw pins (synchronised here, one pulse per press
 made by edge detection) and that an outer store answers nv_req.
*/
// Implementation choices: register access over APB and the register offsets.
// Notes on behaviour
// - up/down step, saturate at parameter limits
// - fast only with up or down held
// - set writes edited value to storage
// - uncommitted edit lost; committed value stays valid
// - save indication, then done ~1 s, value
// - reset in edit returns to monitor number
// - reset after fault clears restores previous number
// - parameter 10 guards basic group 11-3a
// - parameter 50 guards mode group 51-8f
// - protection 0 blocks, 1 allows edits
// - both protections default to zero
// - tens change clears units digit
// - shift: tens, units, edit with indicators dark
// - running blocks edit of no-run parameters
// - modified uncommitted value flashes
// - commit stops flashing
// - fault blocks all parameter edits
// - 9b raised 0 to 1 saves all, ~3 s
// - after bulk save 9b returns to zero, 9a is left at one
// - odd-unit lamp for other or no unit
// - value and unit held until new function
// - after commit, indicator on units digit
module keypad_parameter_editor
   import keypad_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // keys from panel pins, active high
   input wire logic key_up,
   input wire logic key_down,
   input wire logic key_fast,
   input wire logic key_shift,
   input wire logic key_set,
   input wire logic key_reset,
   // display
   output logic [7:0] function_number,
   output logic tens_lamp,
   output logic units_lamp,
   output logic [15:0] data_value,
   output logic data_flash,
   output logic show_saving,
   output logic show_done,
   output logic odd_unit_lamp,
   // nonvolatile store request
   output logic nv_req,
   output logic nv_all
);

   // key synchronisers
   logic [5:0] key_meta_reg;
   logic [5:0] key_sync_reg;
   logic [5:0] key_prev_reg;
   logic [5:0] press;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_meta_reg <= 6'h00;
         key_sync_reg <= 6'h00;
         key_prev_reg <= 6'h00;
      end else begin
         key_meta_reg <= {key_reset, key_set, key_shift, key_fast,
                          key_down, key_up};
         key_sync_reg <= key_meta_reg;
         key_prev_reg <= key_sync_reg;
      end
   end
   assign press = key_sync_reg & ~key_prev_reg;
   logic up_p, down_p, shift_p, set_p, reset_p, fast_held;
   assign up_p = press[0];
   assign down_p = press[1];
   assign shift_p = press[3];
   assign set_p = press[4];
   assign reset_p = press[5];
   // fast alone does nothing; it only widens an up/down step
   assign fast_held = key_sync_reg[2] & (key_sync_reg[0] | key_sync_reg[1]);
   logic [15:0] step;
   assign step = fast_held ? fast_step : 16'h0001;

   // software-visible state, plus internal pre_fault_fn_reg and timer_reg
   logic [5:0] ctrl_reg;
   logic [15:0] lower_reg;
   logic [15:0] upper_reg;
   logic [15:0] nv_value_reg;
   logic [15:0] edit_reg;
   logic prot_basic_reg;
   logic prot_mode_reg;
   logic save_check_reg;
   logic all_save_reg;
   logic dirty_reg;
   mode_type mode_reg;
   logic [7:0] fn_reg;
   logic [7:0] monitor_fn_reg;
   logic [7:0] pre_fault_fn_reg;
   logic fault_seen_reg;
   logic [31:0] timer_reg;

   logic running, fault, fault_gone, no_run_edit;
   assign running = ctrl_reg[ctrl_running_bit];
   assign fault = ctrl_reg[ctrl_fault_bit];
   assign fault_gone = ctrl_reg[ctrl_fault_gone_bit];
   assign no_run_edit = ctrl_reg[ctrl_no_run_edit_bit];

   // edit permission
   logic in_basic, in_mode, is_prot, may_edit, is_monitor;
   assign in_basic = fn_reg >= fn_basic_lo && fn_reg <= fn_basic_hi;
   assign in_mode = fn_reg >= fn_mode_lo && fn_reg <= fn_mode_hi;
   assign is_prot = fn_reg == fn_prot_basic || fn_reg == fn_prot_mode;
   assign is_monitor = fn_reg[7:4] == 4'h0 || fn_reg[7:4] == 4'h4;
   always_comb begin
      may_edit = !is_monitor;
      if (fault)
         may_edit = 1'b0;
      if (in_basic && !prot_basic_reg)
         may_edit = 1'b0;
      if (in_mode && !prot_mode_reg)
         may_edit = 1'b0;
      if (running && no_run_edit)
         may_edit = 1'b0;
   end

   // apb access; zero wait states
   logic wr_en, rd_en;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   logic bad_addr;
   assign bad_addr = !(paddr == ctrl_off || paddr == status_off ||
                       paddr == sel_off || paddr == value_off ||
                       paddr == limit_off || paddr == nv_off);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= 6'h00;
         lower_reg <= 16'h0000;
         upper_reg <= upper_reset;
      end else if (wr_en && paddr == ctrl_off) begin
         ctrl_reg <= pwdata[5:0];
      end else if (wr_en && paddr == limit_off) begin
         lower_reg <= pwdata[15:0];
         upper_reg <= pwdata[31:16];
      end else begin
         ctrl_reg[ctrl_nv_done_bit] <= 1'b0;
      end
   end

   logic write_done;
   assign write_done = ctrl_reg[ctrl_nv_done_bit];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && bad_addr;
         if (rd_en) begin
            unique case (paddr)
               ctrl_off: prdata <= {26'h0, ctrl_reg};
               status_off: prdata <= {20'h0, fault_seen_reg,
                  save_check_reg, all_save_reg, prot_mode_reg,
                  prot_basic_reg, dirty_reg, 3'h0, mode_reg};
               sel_off: prdata <= {16'h0, monitor_fn_reg, fn_reg};
               value_off: prdata <= {16'h0, edit_reg};
               limit_off: prdata <= {upper_reg, lower_reg};
               nv_off: prdata <= {16'h0, nv_value_reg};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // value loaded when a function is chosen; software supplies it via
   // the value register, the edit copy is working storage only
   logic load_value;
   assign load_value = wr_en && paddr == value_off;

   // main sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= st_tens;
         fn_reg <= fn_reset;
         monitor_fn_reg <= fn_reset;
         pre_fault_fn_reg <= fn_reset;
         fault_seen_reg <= 1'b0;
         edit_reg <= 16'h0000;
         nv_value_reg <= 16'h0000;
         dirty_reg <= 1'b0;
         prot_basic_reg <= prot_reset;
         prot_mode_reg <= prot_reset;
         save_check_reg <= 1'b0;
         all_save_reg <= 1'b0;
         timer_reg <= 32'h0;
         nv_req <= 1'b0;
         nv_all <= 1'b0;
      end else begin
         nv_req <= 1'b0;
         if (load_value) begin
            edit_reg <= pwdata[15:0];
            nv_value_reg <= pwdata[15:0];
            dirty_reg <= 1'b0;
         end
         if (fault && !fault_seen_reg) begin
            fault_seen_reg <= 1'b1;
            pre_fault_fn_reg <= fn_reg;
            fn_reg <= fn_fault;
            mode_reg <= st_units;
         end else if (reset_p && fault_seen_reg && fault_gone) begin
            fault_seen_reg <= 1'b0;
            fn_reg <= pre_fault_fn_reg;
            mode_reg <= st_units;
         end else if (reset_p && mode_reg == st_edit) begin
            fn_reg <= monitor_fn_reg;
            mode_reg <= st_units;
            edit_reg <= nv_value_reg;
            dirty_reg <= 1'b0;
         end else begin
            unique case (mode_reg)
               st_tens: begin
                  if (shift_p)
                     mode_reg <= st_units;
                  else if (up_p && fn_reg[7:4] != 4'h9)
                     fn_reg <= {fn_reg[7:4] + 4'h1, 4'h0};
                  else if (down_p && fn_reg[7:4] != 4'h0)
                     fn_reg <= {fn_reg[7:4] - 4'h1, 4'h0};
               end
               st_units: begin
                  if (shift_p)
                     mode_reg <= may_edit || is_prot ? st_edit : st_tens;
                  else if (up_p)
                     fn_reg[3:0] <= fn_reg[3:0] + 4'h1;
                  else if (down_p)
                     fn_reg[3:0] <= fn_reg[3:0] - 4'h1;
                  if (fn_reg[7:4] == 4'h0 && fn_reg[3:0] != 4'h0)
                     monitor_fn_reg <= fn_reg;
               end
               st_edit: begin
                  if (shift_p) begin
                     mode_reg <= st_tens;
                  end else if (is_prot && !fault && (up_p || down_p)) begin
                     if (fn_reg == fn_prot_basic)
                        prot_basic_reg <= up_p;
                     else
                        prot_mode_reg <= up_p;
                  end else if (fn_reg == fn_all_save && up_p &&
                               !all_save_reg && !fault) begin
                     all_save_reg <= 1'b1;
                     mode_reg <= st_all_save;
                     timer_reg <= 32'h0;
                     nv_req <= 1'b1;
                     nv_all <= 1'b1;
                  end else if (may_edit && up_p) begin
                     dirty_reg <= 1'b1;
                     edit_reg <= (upper_reg - edit_reg < step) ?
                        upper_reg : edit_reg + step;
                  end else if (may_edit && down_p) begin
                     dirty_reg <= 1'b1;
                     edit_reg <= (edit_reg - lower_reg < step) ?
                        lower_reg : edit_reg - step;
                  end else if (set_p && may_edit) begin
                     mode_reg <= st_write;
                     nv_req <= 1'b1;
                     nv_all <= 1'b0;
                  end
               end
               st_write: begin
                  if (write_done) begin
                     nv_value_reg <= edit_reg;
                     dirty_reg <= 1'b0;
                     timer_reg <= 32'h0;
                     mode_reg <= st_done;
                  end
               end
               st_done: begin
                  if (timer_reg == save_cycles - 1)
                     mode_reg <= st_units;
                  else
                     timer_reg <= timer_reg + 32'h1;
               end
               st_all_save: begin
                  if (timer_reg >= all_save_cycles - 1 && write_done) begin
                     save_check_reg <= 1'b0;
                     all_save_reg <= 1'b0;
                     dirty_reg <= 1'b0;
                     nv_value_reg <= edit_reg;
                     mode_reg <= st_edit;
                  end else if (timer_reg < all_save_cycles - 1) begin
                     timer_reg <= timer_reg + 32'h1;
                  end
                  if (write_done)
                     save_check_reg <= 1'b1;
               end
               default: mode_reg <= st_tens;
            endcase
         end
      end
   end

   // registered display outputs; value held until function changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         function_number <= fn_reset;
         tens_lamp <= 1'b0;
         units_lamp <= 1'b0;
         data_value <= 16'h0000;
         data_flash <= 1'b0;
         show_saving <= 1'b0;
         show_done <= 1'b0;
         odd_unit_lamp <= 1'b0;
      end else begin
         function_number <= fn_reg;
         tens_lamp <= mode_reg == st_tens;
         units_lamp <= mode_reg == st_units;
         data_value <= edit_reg;
         data_flash <= dirty_reg && mode_reg == st_edit;
         show_saving <= mode_reg == st_write || mode_reg == st_all_save;
         show_done <= mode_reg == st_done;
         odd_unit_lamp <= ctrl_reg[ctrl_no_unit_bit];
      end
   end

endmodule : keypad_parameter_editor

// ==== logic/keypad_pkg.sv ====
/*
 keypad_pkg: constants, register map and state codes for the keypad
 parameter editor.
 Assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
package keypad_pkg;
   // apb byte offsets
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] status_off = 8'h04;
   localparam logic [7:0] sel_off = 8'h08;
   localparam logic [7:0] value_off = 8'h0c;
   localparam logic [7:0] limit_off = 8'h10;
   localparam logic [7:0] nv_off = 8'h14;
   // ctrl bit positions
   localparam int ctrl_running_bit = 0;
   localparam int ctrl_fault_bit = 1;
   localparam int ctrl_fault_gone_bit = 2;
   localparam int ctrl_no_run_edit_bit = 3;
   localparam int ctrl_no_unit_bit = 4;
   localparam int ctrl_nv_done_bit = 5;
   // function numbers of note
   localparam logic [7:0] fn_prot_basic = 8'h10;
   localparam logic [7:0] fn_basic_lo = 8'h11;
   localparam logic [7:0] fn_basic_hi = 8'h3a;
   localparam logic [7:0] fn_prot_mode = 8'h50;
   localparam logic [7:0] fn_mode_lo = 8'h51;
   localparam logic [7:0] fn_mode_hi = 8'h8f;
   localparam logic [7:0] fn_fault = 8'h40;
   localparam logic [7:0] fn_save_check = 8'h9a;
   localparam logic [7:0] fn_all_save = 8'h9b;
   localparam logic [7:0] fn_monitor_first = 8'h01;
   // reset values and the fast step size
   localparam logic [7:0] fn_reset = 8'h01;
   localparam logic prot_reset = 1'b0;
   localparam logic [15:0] upper_reset = 16'hffff;
   localparam logic [15:0] fast_step = 16'h000a;
   // timing
   localparam int clk_hz = 100_000_000;
   localparam int save_ms = 1000;
   localparam int all_save_ms = 3000;
   localparam int save_cycles = clk_hz / 1000 * save_ms;
   localparam int all_save_cycles = clk_hz / 1000 * all_save_ms;

   typedef enum logic [2:0] {
      st_tens = 3'b000,
      st_units = 3'b001,
      st_edit = 3'b010,
      st_write = 3'b011,
      st_done = 3'b100,
      st_all_save = 3'b101
   } mode_type;
endpackage : keypad_pkg

// ==== tb/keypad_operator.sv ====
/*
 keypad_operator: panel operator model pressing the six keys.
 Assumes the bench calls tap or drive from its main sequence.
*/
module keypad_operator (
   // clock
   input wire logic pclk,
   // keys, active high
   output logic key_up,
   output logic key_down,
   output logic key_fast,
   output logic key_shift,
   output logic key_set,
   output logic key_reset
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] keys_reg = 6'h00;
   // released buttons rest at 0, as a pulled-down contact would
   assign {key_reset, key_set, key_shift, key_fast, key_down,
      key_up} = keys_reg;
   // six cycles exceeds the 3-cycle hold and release minimum
   task automatic drive(input logic [5:0] m);
      @(posedge pclk);
      keys_reg <= m;
      repeat (5) @(posedge pclk);
   endtask : drive
   task automatic tap(input logic [5:0] m);
      drive(m);
      drive(6'h00);
   endtask : tap
endmodule : keypad_operator

// ==== tb/keypad_parameter_editor_properties.sv ====
/*
 keypad_checker: port-level assertions on the keypad editor.
 Assumes bind into keypad_parameter_editor, single pclk domain.
*/
module keypad_checker
   import keypad_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // display and store
   input wire logic [7:0] function_number,
   input wire logic tens_lamp,
   input wire logic units_lamp,
   input wire logic data_flash,
   input wire logic show_saving,
   input wire logic show_done,
   input wire logic odd_unit_lamp,
   input wire logic nv_req,
   input wire logic nv_all
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic ctrl_wr;
   logic unit_want_reg;
   assign ctrl_wr = psel && penable && pready && pwrite && paddr == ctrl_off;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_want_reg <= 1'b0;
      end else if (ctrl_wr) begin
         unit_want_reg <= pwdata[ctrl_no_unit_bit];
      end
   end
   zero_wait_a: assert property (psel && !penable |=> pready)
      else $error("access cycle without ready");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   store_pulse_a: assert property (
      nv_req |=> !nv_req) else $error("store request not a pulse");
   saving_shown_a: assert property (
      nv_req |-> ##[0:1] show_saving) else $error("no saving shown");
   done_alone_a: assert property (
      show_done |-> !show_saving) else $error("done while saving");
   flash_stop_a: assert property (
      nv_req && !nv_all |-> ##[0:2] !data_flash)
      else $error("flash kept after commit");
   units_cleared_a: assert property (
      tens_lamp && $past(tens_lamp)
      && function_number[7:4] != $past(function_number[7:4])
      |-> function_number[3:0] == 4'h0) else $error("units not cleared");
   lamps_one_a: assert property (
      !(tens_lamp && units_lamp)) else $error("both digit lamps lit");
   unit_lamp_a: assert property (
      ctrl_wr |=> ##[0:1] odd_unit_lamp == unit_want_reg)
      else $error("unit lamp wrong");
   fault_jump_a: assert property (
      ctrl_wr && pwdata[ctrl_fault_bit] |-> ##[1:4]
      function_number == fn_fault) else $error("no fault display");
endmodule : keypad_checker

bind keypad_parameter_editor keypad_checker u_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
   .function_number, .tens_lamp, .units_lamp, .data_flash,
   .show_saving, .show_done, .odd_unit_lamp, .nv_req, .nv_all);

// ==== tb/keypad_parameter_editor_tb_top.sv ====
/*
 keypad_parameter_editor_tb_top: directed bench for the keypad editor.
 Assumes keypad_operator presses keys and this module is the APB master.
*/
module keypad_parameter_editor_tb_top;
   import keypad_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [5:0] k_up = 6'h01, k_down = 6'h02, k_fast = 6'h04;
   localparam logic [5:0] k_shift = 6'h08, k_set = 6'h10, k_rst = 6'h20;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr;
   logic key_up, key_down, key_fast, key_shift, key_set, key_reset;
   logic [7:0] function_number;
   logic [15:0] data_value;
   logic tens_lamp, units_lamp, data_flash, show_saving, show_done;
   logic odd_unit_lamp, nv_req, nv_all;
   int bad_count = 0, checked = 0;
   always #5 pclk = ~pclk;
   keypad_parameter_editor u_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .key_up,
      .key_down, .key_fast, .key_shift, .key_set, .key_reset,
      .function_number, .tens_lamp, .units_lamp, .data_value,
      .data_flash, .show_saving, .show_done, .odd_unit_lamp, .nv_req,
      .nv_all);
   keypad_operator u_panel (.pclk, .key_up, .key_down, .key_fast,
      .key_shift, .key_set, .key_reset);
   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         bad_count++;
         stop_test();
      end
   endtask : apb
   task automatic t_reset();
      chk("fn", function_number, 8'h01);
      apb(1'b0, status_off, 32'h0);
      chk("protections", rdat[8:7], 2'b00);
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", rerr, 1'b1);
      chk("unmapped", rdat, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_select();
      u_panel.tap(k_up);
      chk("fn", function_number, 8'h10);
      u_panel.tap(k_shift);
      chk("lamps", {tens_lamp, units_lamp}, 2'b01);
      u_panel.tap(k_up);
      chk("fn", function_number, 8'h11);
      // protected group: shift falls back to tens
      u_panel.tap(k_shift);
      chk("lamps", {tens_lamp, units_lamp}, 2'b10);
      u_panel.tap(k_shift);
      u_panel.tap(k_down);
      chk("fn", function_number, 8'h10);
      $display("select test done");
   endtask : t_select
   task automatic t_fault();
      apb(1'b1, ctrl_off, 32'h12);
      apb(1'b0, status_off, 32'h0);
      chk("fn", function_number, fn_fault);
      chk("unit lamp", odd_unit_lamp, 1'b1);
      apb(1'b1, ctrl_off, 32'h04);
      u_panel.tap(k_rst);
      chk("fn", function_number, 8'h10);
      $display("fault test done");
   endtask : t_fault
   task automatic t_edit();
      for (int i = 0; i < 3 && (tens_lamp | units_lamp); i++) begin
         u_panel.tap(k_shift);
      end
      chk("lamps", {tens_lamp, units_lamp}, 2'b00);
      // up on a protection number lifts protection, not the value
      u_panel.tap(k_up);
      apb(1'b0, status_off, 32'h0);
      chk("prot10 up", rdat[7], 1'b1);
      // move to the first basic parameter, now editable
      u_panel.tap(k_shift);
      u_panel.tap(k_shift);
      u_panel.tap(k_up);
      chk("fn", function_number, 8'h11);
      u_panel.tap(k_shift);
      chk("lamps", {tens_lamp, units_lamp}, 2'b00);
      apb(1'b1, limit_off, 32'h0014_0000);
      u_panel.tap(k_up);
      chk("value", data_value, 16'h0001);
      chk("flash", data_flash, 1'b1);
      u_panel.tap(k_fast);
      chk("value", data_value, 16'h0001);
      u_panel.drive(k_fast);
      u_panel.drive(k_fast | k_up);
      chk("value", data_value, 16'h0001 + fast_step);
      u_panel.drive(k_fast);
      u_panel.drive(k_fast | k_up);
      u_panel.drive(6'h00);
      chk("value", data_value, 16'h0014);
      u_panel.tap(k_down);
      chk("value", data_value, 16'h0013);
      for (int i = 0; i < 20; i++) begin
         u_panel.tap(k_down);
      end
      chk("value", data_value, 16'h0000);
      u_panel.tap(k_up);
      $display("edit test done");
   endtask : t_edit
   task automatic t_commit();
      u_panel.tap(k_set);
      chk("saving", show_saving, 1'b1);
      chk("flash", data_flash, 1'b0);
      apb(1'b1, ctrl_off, 32'h20);
      apb(1'b0, nv_off, 32'h0);
      chk("stored", rdat, 32'h1);
      chk("done", {show_done, show_saving}, 2'b10);
      apb(1'b0, status_off, 32'h0);
      chk("prot10", rdat[7], 1'b1);
      $display("commit test done");
   endtask : t_commit
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_select();
      t_fault();
      t_edit();
      t_commit();
      stop_test();
   end
endmodule : keypad_parameter_editor_tb_top
